// file: rtl/fpep_pkg.sv
//----------------------------------------------------------------------
// Shared constants for the program/erase/protect block
//----------------------------------------------------------------------
package fpep_pkg;

  //--------------------------------------------------------------------
  // Register map (index; byte address is four times the index)
  //--------------------------------------------------------------------
  localparam int          AXI_AW       = 18;           // Bus address width
  localparam logic [15:0] CTRL_IDX     = 16'hfe08;     // Control register index
  localparam logic [15:0] PROT_IDX     = 16'hfe09;     // Protect start index

  //--------------------------------------------------------------------
  // Control field positions and reset values
  //--------------------------------------------------------------------
  localparam int          CTL_PGM      = 0;            // Program select
  localparam int          CTL_ERASE    = 1;            // Erase select
  localparam int          CTL_MASS     = 2;            // Whole-array select
  localparam int          CTL_HV       = 3;            // Charge pump enable
  localparam logic [7:0]  CTRL_RST     = 8'h00;        // Control after reset
  localparam logic [7:0]  PROT_RST     = 8'h00;        // Protect after reset

  //--------------------------------------------------------------------
  // Array geometry
  //--------------------------------------------------------------------
  localparam int          PAGE_LSB     = 9;            // 512-byte pages
  localparam int          ROW_LSB      = 6;            // 64-byte rows
  localparam logic [15:0] OPT_BYTE     = 16'hffcf;     // Option byte address
  localparam logic [15:0] VEC_TOP      = 16'hffff;     // Last vector byte
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;        // Erased cells read one

  //--------------------------------------------------------------------
  // Protect-start decode points
  //--------------------------------------------------------------------
  localparam logic [7:0]  PROT_ALL_MAX = 8'h09;        // Start below array
  localparam logic [7:0]  PROT_VEC_MIN = 8'hfc;        // Only fixed region
  localparam logic [7:0]  PROT_NONE    = 8'hff;        // No block protection

  //--------------------------------------------------------------------
  // Bus responses
  //--------------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  //--------------------------------------------------------------------
  // Sequence tracker states
  //--------------------------------------------------------------------
  typedef enum logic [1:0] {
    SQ_IDLE,                                           // No operation selected
    SQ_SEL,                                            // Selected, no address yet
    SQ_LATCHED                                         // Target address latched
  } fpep_seq_t;

endpackage : fpep_pkg

// file: rtl/fpep_top.sv
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps

// Functional notes
// - Erased bits read one, programmed zero
// - Page erase removes 512 bytes minimum
// - Pump enable needs select and order
// - Whole-array bit picks mass or page
// - Erase and program selects never both
// - Erased page aligned, holds latched address
// - Page erase keeps the vector region
// - Rows of 64; select enables latching
// - Protected target refuses pump enable
// - Option byte and vectors protected except from mass erase
// - Protect bits form start address high
// - All ones disables block protection
// - Low values protect all; FC-FE fixed
// - Control bit layout, upper bits zero
module fpep_top
  import fpep_pkg::*;
(
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [fpep_pkg::AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output      logic                          s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output      logic                          s_axi_wready,
  output      logic [1:0]                    s_axi_bresp,
  output      logic                          s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [fpep_pkg::AXI_AW-1:0]   s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output      logic                          s_axi_arready,
  output      logic [31:0]                   s_axi_rdata,
  output      logic [1:0]                    s_axi_rresp,
  output      logic                          s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          mem_wr,
  input  wire logic [15:0]                   mem_addr,
  input  wire logic [7:0]                    mem_wdata,
  output      logic                          charge_pump_on,
  output      logic                          nv_page_erase,
  output      logic                          nv_mass_erase,
  output      logic                          nv_keep_vectors,
  output      logic [15:0]                   nv_erase_base,
  output      logic [7:0]                    nv_erase_fill,
  output      logic                          nv_prog_stb,
  output      logic [15:0]                   nv_prog_addr,
  output      logic [7:0]                    nv_prog_data,
  output      logic                          seq_latched
);

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  logic              aw_got_r;                 // Write address held
  logic              w_got_r;                  // Write data held
  logic [15:0]       aw_idx_r;                 // Held write index
  logic [7:0]        w_byte_r;                 // Held write low byte
  logic              w_lane_r;                 // Low byte lane enabled
  logic              bvalid_r;                 // Write response pending
  logic [1:0]        bresp_r;                  // Write response code
  logic              rvalid_r;                 // Read data pending
  logic [7:0]        rdata_r;                  // Read data byte
  logic [1:0]        rresp_r;                  // Read response code
  logic              pgm_r;                    // Program select
  logic              erase_r;                  // Erase select
  logic              mass_r;                   // Whole-array select
  logic              hv_r;                     // Charge pump enable
  logic [7:0]        prot_r;                   // Protect start bits
  fpep_seq_t         seq_r;                    // Sequence tracker
  fpep_seq_t         seq_nxt;
  logic [15:0]       lat_addr_r;               // Latched target address
  logic              prog_stb_r;               // Program strobe
  logic [15:0]       prog_addr_r;              // Program address
  logic [7:0]        prog_data_r;              // Program data

  //--------------------------------------------------------------------
  // Bus write decode
  //--------------------------------------------------------------------
  wire        aw_take   = s_axi_awvalid & s_axi_awready;
  wire        w_take    = s_axi_wvalid & s_axi_wready;
  // Both halves present this cycle, either held or arriving now
  wire        aw_have   = aw_got_r | aw_take;
  wire        w_have    = w_got_r | w_take;
  wire        wr_fire   = aw_have & w_have & ~bvalid_r;
  wire [15:0] wr_idx    = aw_got_r ? aw_idx_r : s_axi_awaddr[AXI_AW-1:2];
  wire [7:0]  wr_byte   = w_got_r ? w_byte_r : s_axi_wdata[7:0];
  wire        wr_lane   = w_got_r ? w_lane_r : s_axi_wstrb[0];
  wire        wr_ctrl   = wr_fire & (wr_idx == CTRL_IDX);
  wire        wr_prot   = wr_fire & (wr_idx == PROT_IDX);
  wire        wr_hit    = (wr_idx == CTRL_IDX) | (wr_idx == PROT_IDX);
  wire        ctl_we    = wr_ctrl & wr_lane;
  wire        prot_we   = wr_prot & wr_lane;

  //--------------------------------------------------------------------
  // Bus read decode
  //--------------------------------------------------------------------
  wire        ar_take   = s_axi_arvalid & s_axi_arready;
  wire [15:0] rd_idx    = s_axi_araddr[AXI_AW-1:2];
  wire        rd_ctrl   = rd_idx == CTRL_IDX;
  wire        rd_prot   = rd_idx == PROT_IDX;
  // Upper control bits are unimplemented and read as zero
  wire [7:0]  ctrl_view = {4'h0, hv_r, mass_r, erase_r, pgm_r};
  wire [7:0]  rd_byte   = rd_ctrl ? ctrl_view : (rd_prot ? prot_r : 8'h00);

  //--------------------------------------------------------------------
  // Protection decode
  //--------------------------------------------------------------------
  // Protect bits 7..1 give address bits 15..9, lower bits zero
  wire [15:0] prot_start = {prot_r[7:1], 9'h000};
  // Bit zero only matters for the all-ones value
  wire        prot_off   = prot_r == PROT_NONE;
  // Start below the array means everything is covered
  wire        prot_all   = prot_r <= PROT_ALL_MAX;
  wire        prot_fixed = ~prot_off & (prot_r >= PROT_VEC_MIN);

  // Fixed region: option byte and the vectors above it
  function automatic logic fixed_zone(input logic [15:0] a);
    fixed_zone = (a >= OPT_BYTE) & (a <= VEC_TOP);
  endfunction : fixed_zone

  // Range set by the protect bits, not counting the fixed region
  function automatic logic block_zone(input logic [15:0] a,
                                      input logic        off,
                                      input logic        all,
                                      input logic        fixd,
                                      input logic [15:0] start);
    // Off wins, then cover-all, then fixed-only, else from the start up
    block_zone = ~off & (all | (~fixd & (a >= start)));
  endfunction : block_zone

  // Latched target against the protected range
  wire lat_block = block_zone(lat_addr_r, prot_off, prot_all, prot_fixed, prot_start);
  // Byte write target against the protected range
  wire mem_block = block_zone(mem_addr, prot_off, prot_all, prot_fixed, prot_start);
  // Program may never touch the fixed region; erase clears it by mass only
  wire lat_refuse_pgm   = lat_block | fixed_zone(lat_addr_r);
  wire lat_refuse_erase = lat_block | (fixed_zone(lat_addr_r) & ~mass_r);

  //--------------------------------------------------------------------
  // Control register next value
  //--------------------------------------------------------------------
  wire wr_pgm   = wr_byte[CTL_PGM];
  wire wr_erase = wr_byte[CTL_ERASE];
  wire wr_mass  = wr_byte[CTL_MASS];
  wire wr_hv    = wr_byte[CTL_HV];

  // Asking for both selects at once leaves neither set
  wire pgm_nxt   = ctl_we ? (wr_pgm & ~wr_erase) : pgm_r;
  wire erase_nxt = ctl_we ? (wr_erase & ~wr_pgm) : erase_r;
  wire mass_nxt  = ctl_we ? wr_mass : mass_r;

  // A changed selection restarts address latching
  wire sel_any  = pgm_nxt | erase_nxt;
  wire sel_chg  = (pgm_nxt != pgm_r) | (erase_nxt != erase_r) |
                  (mass_nxt != mass_r);

  // Pump may only come on for a select already held and latched
  wire hv_mode_ok = (wr_pgm & pgm_r & pgm_nxt & ~lat_refuse_pgm) |
                    (wr_erase & erase_r & erase_nxt & ~lat_refuse_erase);
  // A mode change in the same write would skip the latch step
  wire hv_set_ok  = hv_mode_ok & ~sel_chg & (seq_r == SQ_LATCHED);
  // Clearing is always honoured; setting needs the checks above
  wire hv_nxt     = ctl_we ? (wr_hv & (hv_r | hv_set_ok)) : hv_r;

  //--------------------------------------------------------------------
  // Sequence tracker
  //--------------------------------------------------------------------
  // Follows the select and latch steps
  always_comb
  begin
    seq_nxt = seq_r;
    case (seq_r)
      // Waiting for a select bit
      SQ_IDLE:    seq_nxt = sel_any ? SQ_SEL : SQ_IDLE;
      // First array write picks the target
      SQ_SEL:     seq_nxt = !sel_any ? SQ_IDLE :
                            ((mem_wr && !sel_chg) ? SQ_LATCHED : SQ_SEL);
      // Held until the select is dropped or changed
      SQ_LATCHED: seq_nxt = !sel_any ? SQ_IDLE : (sel_chg ? SQ_SEL : SQ_LATCHED);
      default:    seq_nxt = SQ_IDLE;
    endcase
  end

  // Latch happens on the step-two write only
  wire lat_take = (seq_r == SQ_SEL) & (seq_nxt == SQ_LATCHED);

  //--------------------------------------------------------------------
  // Row programming
  //--------------------------------------------------------------------
  // Bytes outside the latched row are dropped, as are protected ones
  wire same_row = mem_addr[15:ROW_LSB] == lat_addr_r[15:ROW_LSB];
  wire prog_go  = mem_wr & hv_r & pgm_r & (seq_r == SQ_LATCHED) &
                  same_row & ~mem_block & ~fixed_zone(mem_addr);

  //--------------------------------------------------------------------
  // Bus channel processes
  //--------------------------------------------------------------------
  // Holds address and data halves until both are present
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      aw_idx_r <= 16'h0000;
      w_byte_r <= 8'h00;
      w_lane_r <= 1'b0;
    end
    else
    begin
      aw_got_r <= aw_have & ~wr_fire;
      w_got_r  <= w_have & ~wr_fire;
      if (aw_take)
      begin
        aw_idx_r <= s_axi_awaddr[AXI_AW-1:2];
      end
      if (w_take)
      begin
        w_byte_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end
    end
  end

  // Write response; unmapped index answers with slave error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_r <= 1'b0;
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 8'h00;
      rresp_r  <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_byte;
      rresp_r  <= (rd_ctrl | rd_prot) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_r <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // Control and protect registers
  //--------------------------------------------------------------------
  // Software view; pump bit is the only timing source
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pgm_r   <= CTRL_RST[CTL_PGM];
      erase_r <= CTRL_RST[CTL_ERASE];
      mass_r  <= CTRL_RST[CTL_MASS];
      hv_r    <= CTRL_RST[CTL_HV];
      prot_r  <= PROT_RST;
    end
    else
    begin
      pgm_r   <= pgm_nxt;
      erase_r <= erase_nxt;
      mass_r  <= mass_nxt;
      hv_r    <= hv_nxt;
      if (prot_we)
      begin
        prot_r <= wr_byte;
      end
    end
  end

  // Tracker state and latched target
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seq_r      <= SQ_IDLE;
      lat_addr_r <= 16'h0000;
    end
    else
    begin
      seq_r <= seq_nxt;
      if (lat_take)
      begin
        lat_addr_r <= mem_addr;
      end
    end
  end

  // Program strobe with its address and data, one cycle per byte
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prog_stb_r  <= 1'b0;
      prog_addr_r <= 16'h0000;
      prog_data_r <= ERASED_BYTE;
    end
    else
    begin
      prog_stb_r <= prog_go;
      if (prog_go)
      begin
        prog_addr_r <= mem_addr;
        // Zero bits are the ones the cell gets programmed to
        prog_data_r <= mem_wdata;
      end
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  assign s_axi_awready   = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready    = ~w_got_r & ~bvalid_r;
  assign s_axi_bvalid    = bvalid_r;
  assign s_axi_bresp     = bresp_r;
  assign s_axi_arready   = ~rvalid_r;
  assign s_axi_rvalid    = rvalid_r;
  assign s_axi_rresp     = rresp_r;
  assign s_axi_rdata     = {24'h00_0000, rdata_r};

  assign charge_pump_on  = hv_r;
  // Erase runs while pump and erase select are both on
  assign nv_mass_erase   = hv_r & erase_r & mass_r;
  assign nv_page_erase   = hv_r & erase_r & ~mass_r;
  // Page base: target address with the low nine bits cleared
  assign nv_erase_base   = {lat_addr_r[15:PAGE_LSB], 9'h000};
  // Page erase always spares the fixed region
  assign nv_keep_vectors = ~mass_r;
  assign nv_erase_fill   = ERASED_BYTE;
  assign nv_prog_stb     = prog_stb_r;
  assign nv_prog_addr    = prog_addr_r;
  assign nv_prog_data    = prog_data_r;
  assign seq_latched     = seq_r == SQ_LATCHED;

endmodule : fpep_top

// file: tb/fpep_monitor.sv
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Port checker
//----------------------------------------------------------------------
module fpep_mon
  import fpep_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        charge_pump_on,
  input wire logic        nv_page_erase,
  input wire logic        nv_mass_erase,
  input wire logic        nv_keep_vectors,
  input wire logic [15:0] nv_erase_base,
  input wire logic [7:0]  nv_erase_fill,
  input wire logic        nv_prog_stb,
  input wire logic [15:0] nv_prog_addr,
  input wire logic [7:0]  nv_prog_data,
  input wire logic        seq_latched
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves taken at one edge
  sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  // Read address taken
  sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
  property p_bresp; s_wr |=> s_axi_bvalid; endproperty
  a_bresp: assert property (p_bresp) else $error("write not answered");
  property p_rd; s_rd |=> s_axi_rvalid && (s_axi_rdata[31:8] == 24'h00_0000); endproperty
  a_rd: assert property (p_rd) else $error("read answer late or upper bits set");
  property p_excl; !(nv_page_erase && nv_mass_erase); endproperty
  a_excl: assert property (p_excl) else $error("page and mass erase together");
  property p_pump; (nv_page_erase || nv_mass_erase) |-> charge_pump_on; endproperty
  a_pump: assert property (p_pump) else $error("erase without pump");
  property p_keep; nv_page_erase |-> nv_keep_vectors; endproperty
  a_keep: assert property (p_keep) else $error("page erase may clear vectors");
  property p_mkeep; nv_mass_erase |-> !nv_keep_vectors; endproperty
  a_mkeep: assert property (p_mkeep) else $error("mass erase spares vectors");
  property p_base; (nv_erase_base[8:0] == 9'h000) && (nv_erase_fill == 8'hff); endproperty
  a_base: assert property (p_base) else $error("page base or fill wrong");
  property p_stb;
    nv_prog_stb |-> $past(mem_wr) && (nv_prog_addr == $past(mem_addr))
      && (nv_prog_data == $past(mem_wdata));
  endproperty
  a_stb: assert property (p_stb) else $error("strobe not tied to array write");
  property p_stbvec; nv_prog_stb |-> (nv_prog_addr < OPT_BYTE); endproperty
  a_stbvec: assert property (p_stbvec) else $error("fixed region programmed");
  property p_prise; $rose(charge_pump_on) |-> seq_latched; endproperty
  a_prise: assert property (p_prise) else $error("pump on without latched target");
endmodule : fpep_mon

bind fpep_top fpep_mon fpep_mon_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .mem_wr, .mem_addr, .mem_wdata, .charge_pump_on, .nv_page_erase, .nv_mass_erase,
  .nv_keep_vectors, .nv_erase_base, .nv_erase_fill, .nv_prog_stb, .nv_prog_addr, .nv_prog_data,
  .seq_latched);

// file: tb/tb.sv
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Self-checking bench
//----------------------------------------------------------------------
module tb;
  import fpep_pkg::*;
  localparam logic [17:0] ACTL = 18'h3_f820;           // Control word address
  localparam logic [17:0] APRT = 18'h3_f824;           // Protect word address
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, mem_wr = 1'b0;
  logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = '0;
  logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;  // Protection bits unused
  logic [15:0] mem_addr = '0, nv_erase_base, nv_prog_addr, a;
  logic [7:0]  mem_wdata = '0, nv_erase_fill, nv_prog_data, v, d;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        charge_pump_on, nv_page_erase, nv_mass_erase, nv_keep_vectors;
  logic        nv_prog_stb, seq_latched, s;
  logic [7:0]  pvs [8] = '{8'h00, 8'h09, 8'h0a, 8'h0b, 8'h00, 8'hfc, 8'hfe, 8'hff};
  int          n_errors = 0, n_tests = 0, cyc = 0;

  fpep_top fpep_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_wr, .mem_addr, .mem_wdata,
    .charge_pump_on, .nv_page_erase, .nv_mass_erase, .nv_keep_vectors, .nv_erase_base,
    .nv_erase_fill, .nv_prog_stb, .nv_prog_addr, .nv_prog_data, .seq_latched);

  // 40 MHz clock
  always #12.5 aclk = ~aclk;

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // Hang guard, far above the several hundred cycles needed
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Bus write; readies sampled mid-cycle so the edge decision is race free
  task automatic wr(input logic [17:0] ad, input logic [7:0] dt, input logic [3:0] st,
                    input logic [1:0] er);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'($urandom), dt};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      @(posedge aclk);
      da = da | ta;
      dw = dw | tw;
      s_axi_awvalid <= s_axi_awvalid & ~ta;
      s_axi_wvalid <= s_axi_wvalid & ~tw;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [17:0] ad, input logic [7:0] exp, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    chk({s_axi_rresp, s_axi_rdata}, {er, 24'h00_0000, exp});
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rdc

  // Array write pulse; strobe seen one cycle later
  task automatic mw(input logic [15:0] ad, input logic [7:0] dt);
    @(posedge aclk);
    mem_wr <= 1'b1;
    mem_addr <= ad;
    mem_wdata <= dt;
    @(posedge aclk);
    mem_wr <= 1'b0;
    @(negedge aclk);
    s = nv_prog_stb;
  endtask : mw

  // Page erase target refused: fixed region always, else the protect range
  function automatic logic hit(input logic [7:0] pv, input logic [15:0] ad);
    if (ad >= 16'hffcf) return 1'b1;
    if (pv == 8'hff) return 1'b0;
    if (pv <= 8'h09) return 1'b1;
    if (pv >= 8'hfc) return 1'b0;
    return ad >= {pv[7:1], 9'h000};
  endfunction : hit

  initial
  begin
    void'($urandom(32'h6866));
    pvs[4] = 8'($urandom_range(8'h0a, 8'hfb));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(ACTL, 8'h00, RESP_OKAY);
    rdc(APRT, 8'h00, RESP_OKAY);
    rdc(18'h0_0010, 8'h00, RESP_SLVERR);
    wr(18'h0_0010, 8'h5a, 4'h1, RESP_SLVERR);
    wr(APRT, 8'h5a, 4'he, RESP_OKAY);
    rdc(APRT, 8'h00, RESP_OKAY);
    wr(ACTL, 8'h03, 4'h1, RESP_OKAY);
    rdc(ACTL, 8'h00, RESP_OKAY);
    wr(ACTL, 8'hf8, 4'h1, RESP_OKAY);
    rdc(ACTL, 8'h00, RESP_OKAY);
    wr(ACTL, 8'h02, 4'h1, RESP_OKAY);
    wr(ACTL, 8'h0a, 4'h1, RESP_OKAY);
    rdc(ACTL, 8'h02, RESP_OKAY);
    wr(ACTL, 8'h00, 4'h1, RESP_OKAY);
    // Page erase across protect values, at and below each start
    foreach (pvs[i])
      for (int k = 0; k < 3; k++)
      begin
        v = pvs[i];
        a = (k == 2) ? ((i == 7) ? 16'hffd0 : 16'($urandom)) : {v[7:1], 9'h000} - 16'(k);
        wr(APRT, v, 4'h1, RESP_OKAY);
        wr(ACTL, 8'h02, 4'h1, RESP_OKAY);
        mw(a, 8'($urandom));
        chk(seq_latched, 1'b1);
        wr(ACTL, 8'h0a, 4'h1, RESP_OKAY);
        rdc(ACTL, hit(v, a) ? 8'h02 : 8'h0a, RESP_OKAY);
        chk({nv_page_erase, nv_mass_erase, nv_keep_vectors, nv_erase_base},
            {~hit(v, a), 2'b01, a & 16'hfe00});
        wr(ACTL, 8'h08, 4'h1, RESP_OKAY);
        wr(ACTL, 8'h00, 4'h1, RESP_OKAY);
      end
    // Mass erase, open and fully protected
    for (int j = 0; j < 2; j++)
    begin
      wr(APRT, j ? 8'h09 : 8'hff, 4'h1, RESP_OKAY);
      wr(ACTL, 8'h06, 4'h1, RESP_OKAY);
      mw(16'($urandom), 8'h00);
      wr(ACTL, 8'h0e, 4'h1, RESP_OKAY);
      rdc(ACTL, j ? 8'h06 : 8'h0e, RESP_OKAY);
      chk({nv_page_erase, nv_mass_erase, nv_keep_vectors}, {1'b0, j == 0, 1'b0});
      wr(ACTL, 8'h0c, 4'h1, RESP_OKAY);
      wr(ACTL, 8'h00, 4'h1, RESP_OKAY);
    end
    // Row program, then a byte outside the row
    wr(APRT, 8'hff, 4'h1, RESP_OKAY);
    a = {10'($urandom_range(0, 1020)), 6'h00};
    wr(ACTL, 8'h01, 4'h1, RESP_OKAY);
    mw(a | 16'($urandom_range(0, 63)), 8'h00);
    wr(ACTL, 8'h09, 4'h1, RESP_OKAY);
    rdc(ACTL, 8'h09, RESP_OKAY);
    for (int b = 0; b < 5; b++)
    begin
      d = (b == 0) ? 8'h00 : 8'($urandom);
      mw(a | ((b == 4) ? 16'h003f : 16'($urandom_range(0, 63))), d);
      chk({s, nv_prog_addr, nv_prog_data}, {1'b1, mem_addr, d});
    end
    mw(a + 16'h0040, 8'h55);
    chk(s, 1'b0);
    wr(ACTL, 8'h08, 4'h1, RESP_OKAY);
    wr(ACTL, 8'h00, 4'h1, RESP_OKAY);
    // Vector region refuses programming even when unprotected
    wr(ACTL, 8'h01, 4'h1, RESP_OKAY);
    mw(16'hffd0, 8'h00);
    wr(ACTL, 8'h09, 4'h1, RESP_OKAY);
    rdc(ACTL, 8'h01, RESP_OKAY);
    wr(ACTL, 8'h00, 4'h1, RESP_OKAY);
    print_verdict();
  end
endmodule : tb
